/* File: cmsd_pkg.sv */
// Purpose: Shared constants and types for the core memory space decoder
// Assumes: 8-bit data space, 16-bit program space
// Notes:   Shared offsets, field positions, the stack pointer reset value and cycle counts live here
package cmsd_pkg;
  localparam logic [7:0]  SFR_BASE        = 8'h80;
  localparam logic [7:0]  STACK_PTR_ADDR  = 8'h81;
  localparam logic [7:0]  STACK_PTR_RESET = 8'h07;
  localparam logic [7:0]  BANK_END        = 8'h1F;
  localparam logic [7:0]  BIT_BYTE_BASE   = 8'h20;
  localparam logic [7:0]  BIT_BYTE_END    = 8'h2F;
  localparam logic [15:0] FACTORY_BASE    = 16'hFE00;
  localparam logic [7:0]  OPC_NOP         = 8'h00;
  localparam logic [7:0]  OPC_UNUSED      = 8'hA5;
  localparam int          STATUS_BANK_LO_BIT = 3;
  localparam int          STATUS_BANK_HI_BIT = 4;
  localparam int          STORE_WREN_BIT     = 0;
  localparam int          PAGE_BITS       = 11;
  localparam int          STACK_REC_W     = 32;
  localparam logic [2:0]  CYC_NOP         = 3'h1;
  localparam logic [2:0]  CYC_BR_SHORT    = 3'h2;
  localparam logic [2:0]  CYC_BR_MID      = 3'h3;
  localparam logic [2:0]  CYC_BR_IND      = 3'h4;

  // Branch kinds; cycle count depends on taken/not taken except for none and no-op
  typedef enum logic [2:0] {
    CMSD_BR_NONE     = 3'h0,
    CMSD_BR_CMP_IND  = 3'h1,
    CMSD_BR_CMP      = 3'h2,
    CMSD_BR_DEC_REG  = 3'h3,
    CMSD_BR_ACC_NZ   = 3'h4,
    CMSD_BR_DEC_DIR  = 3'h5,
    CMSD_BR_NOP      = 3'h6
  } cmsd_branch_t;

  // Jump target form
  typedef enum logic [1:0] {
    CMSD_JMP_REL  = 2'h0,
    CMSD_JMP_PAGE = 2'h1,
    CMSD_JMP_LONG = 2'h2
  } cmsd_jump_t;

  // Data access request from the execution unit
  typedef struct packed {
    logic       valid;
    logic       indirect;
    logic       bit_op;
    logic       use_r1;
    logic [7:0] addr;
  } cmsd_data_req_t;

  // Decoded data access
  typedef struct packed {
    logic       ram_sel;
    logic       sfr_sel;
    logic       bit_op;
    logic       bad_bit;
    logic [7:0] addr;
    logic [2:0] bit_pos;
  } cmsd_data_dec_t;

  // Stack events from the execution unit
  typedef struct packed {
    logic push;
    logic pop;
    logic call;
    logic ret;
    logic inc;
    logic dec;
  } cmsd_stack_ev_t;
endpackage : cmsd_pkg

/* File: cmsd_stack_record.sv */
// Purpose: Debug stack record shift register with overflow and underflow flags
// Assumes: One stack event class per cycle from the execution unit
// Notes:   Flags are sticky until debug clears them; a new overflow or underflow beats the clear
`timescale 1ns/100ps
module cmsd_stack_record #(
  parameter int WIDTH = cmsd_pkg::STACK_REC_W
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire cmsd_pkg::cmsd_stack_ev_t ev,
  input  wire logic                 bit_in,
  input  wire logic                 flag_clear,
  output logic [WIDTH-1:0]          record_reg,
  output logic                      overflow_reg,
  output logic                      underflow_reg
);
  localparam int CW = $clog2(WIDTH + 1);
  logic [CW-1:0] depth_reg;
  logic [1:0]    n_in;
  logic [1:0]    n_out;

  // Bits moved by this event
  always_comb begin
    n_in  = ev.call ? 2'd2 : ((ev.push | ev.inc) ? 2'd1 : 2'd0);
    n_out = ev.ret  ? 2'd2 : ((ev.pop  | ev.dec) ? 2'd1 : 2'd0);
  end

  // Shift the record; pushes enter at bit 0
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      record_reg <= '0;
    end else if (n_in == 2'd2) begin
      record_reg <= {record_reg[WIDTH-3:0], bit_in, bit_in};
    end else if (n_in == 2'd1) begin
      record_reg <= {record_reg[WIDTH-2:0], bit_in};
    end else if (n_out == 2'd2) begin
      record_reg <= {2'b00, record_reg[WIDTH-1:2]};
    end else if (n_out == 2'd1) begin
      record_reg <= {1'b0, record_reg[WIDTH-1:1]};
    end
  end

  // Occupancy saturates so the flags stay meaningful
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      depth_reg <= '0;
    end else if (n_in != 2'd0) begin
      if (depth_reg + CW'(n_in) > CW'(WIDTH)) depth_reg <= CW'(WIDTH);
      else depth_reg <= depth_reg + CW'(n_in);
    end else if (n_out != 2'd0) begin
      if (depth_reg < CW'(n_out)) depth_reg <= '0;
      else depth_reg <= depth_reg - CW'(n_out);
    end
  end

  // Sticky error flags, set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overflow_reg  <= 1'b0;
      underflow_reg <= 1'b0;
    end else begin
      if (n_in != 2'd0 && depth_reg + CW'(n_in) > CW'(WIDTH)) overflow_reg <= 1'b1;
      else if (flag_clear) overflow_reg <= 1'b0;
      if (n_in == 2'd0 && n_out != 2'd0 && depth_reg < CW'(n_out)) underflow_reg <= 1'b1;
      else if (flag_clear) underflow_reg <= 1'b0;
    end
  end
endmodule : cmsd_stack_record

/* File: cmsd_top.sv */
// Purpose: Operand address decode, data memory map, stack pointer and branch timing
// Assumes: Execution unit presents one decoded request per cycle, same clock
// Notes:   All outputs registered, so results appear one cycle after the request
// Operation
// - Relative offset signed, from next instruction
// - Direct below 0x80 RAM, else SPECIAL_FUNCTION_REGISTER
// - Page target replaces low 11 bits
// - Long target reaches whole 64 kB
// - Unused opcode behaves as no-operation
// - Code writes only with store enable set
// - Indirect above 0x7F hits upper RAM
// - Four banks, chosen by status bits
// - Indirect pointer is R0 or R1
// - Bytes 0x20-0x2F hold bit space
// - Bit versus byte by operand type
// - Push writes at pointer+1, then increments
// - Reset loads pointer with 0x07
// - Record shifts one or two bits
// - Record flags overflow and underflow
// - SFRs at x0/x8 bit-addressable
// - Compare branches take 3/4, indirect 4/5
// - Decrement and nonzero branches, no-op timing
// - Top 512 code bytes reserved
`timescale 1ns/100ps
module cmsd_top #(
  parameter int REC_WIDTH = cmsd_pkg::STACK_REC_W
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire cmsd_pkg::cmsd_data_req_t data_req,
  input  wire logic [7:0]               bank_r0,
  input  wire logic [7:0]               bank_r1,
  input  wire logic [7:0]               program_status_word,
  input  wire logic [7:0]               program_store_control,
  input  wire logic                     code_write_req,
  input  wire logic [15:0]              code_write_addr,
  input  wire logic [15:0]              next_pc,
  input  wire cmsd_pkg::cmsd_jump_t     jump_kind,
  input  wire logic                     jump_valid,
  input  wire logic [15:0]              jump_operand,
  input  wire logic [7:0]               opcode,
  input  wire cmsd_pkg::cmsd_branch_t   branch_kind,
  input  wire logic                     branch_taken,
  input  wire cmsd_pkg::cmsd_stack_ev_t stack_ev,
  input  wire logic                     sp_write,
  input  wire logic [7:0]               sp_wdata,
  input  wire logic                     rec_bit_in,
  input  wire logic                     rec_flag_clear,
  output cmsd_pkg::cmsd_data_dec_t      data_dec_reg,
  output logic [4:0]                    bank_reg_base_reg,
  output logic [15:0]                   jump_target_reg,
  output logic                          jump_target_valid_reg,
  output logic                          opcode_is_nop_reg,
  output logic [2:0]                    branch_cycles_reg,
  output logic                          code_write_reg,
  output logic                          code_write_refused_reg,
  output logic [7:0]                    stack_top_pointer_reg,
  output logic [7:0]                    stack_write_addr_reg,
  output logic                          stack_write_reg,
  output logic [REC_WIDTH-1:0]          stack_record_reg,
  output logic                          stack_overflow_reg,
  output logic                          stack_underflow_reg
);
  logic                     rst_meta_reg;
  logic                     rst_n;
  cmsd_pkg::cmsd_data_dec_t data_dec_next;
  logic [15:0]              jump_target_next;
  logic [7:0]               stack_top_pointer_next;
  logic [1:0]               bank_sel;

  // Register bank base: 8 bytes per bank
  function automatic logic [4:0] bank_base(input logic [1:0] sel);
    bank_base = {sel, 3'b000};
  endfunction : bank_base

  // SPECIAL_FUNCTION_REGISTER bit addressing only on column 0 and 8
  function automatic logic sfr_bit_ok(input logic [7:0] a);
    sfr_bit_ok = (a[2:0] == 3'b000);
  endfunction : sfr_bit_ok

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  assign bank_sel = {program_status_word[cmsd_pkg::STATUS_BANK_HI_BIT],
                     program_status_word[cmsd_pkg::STATUS_BANK_LO_BIT]};

  // Data operand decode
  always_comb begin
    data_dec_next         = '0;
    data_dec_next.bit_op  = data_req.valid & data_req.bit_op;
    if (data_req.valid) begin
      if (data_req.indirect) begin
        // Pointer value picks all 256 RAM bytes, never the SFRs
        data_dec_next.addr    = data_req.use_r1 ? bank_r1 : bank_r0;
        data_dec_next.ram_sel = 1'b1;
      end else if (data_req.bit_op) begin
        if (data_req.addr < cmsd_pkg::SFR_BASE) begin
          // Bit 0x00-0x7F maps into bytes 0x20-0x2F
          data_dec_next.addr    = cmsd_pkg::BIT_BYTE_BASE + {4'h0, data_req.addr[6:3]};
          data_dec_next.ram_sel = 1'b1;
        end else begin
          data_dec_next.addr    = {data_req.addr[7:3], 3'b000};
          data_dec_next.sfr_sel = 1'b1;
          data_dec_next.bad_bit = ~sfr_bit_ok({data_req.addr[7:3], 3'b000});
        end
        data_dec_next.bit_pos = data_req.addr[2:0];
      end else begin
        data_dec_next.addr    = data_req.addr;
        data_dec_next.ram_sel = (data_req.addr < cmsd_pkg::SFR_BASE);
        data_dec_next.sfr_sel = (data_req.addr >= cmsd_pkg::SFR_BASE);
      end
    end
  end

  // Decode result and active bank base
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_dec_reg      <= '0;
      bank_reg_base_reg <= 5'h00;
    end else begin
      data_dec_reg      <= data_dec_next;
      bank_reg_base_reg <= bank_base(bank_sel);
    end
  end

  // Jump target arithmetic, relative to the following instruction
  always_comb begin
    case (jump_kind)
      cmsd_pkg::CMSD_JMP_REL:
        jump_target_next = next_pc + {{8{jump_operand[7]}}, jump_operand[7:0]};
      cmsd_pkg::CMSD_JMP_PAGE:
        jump_target_next = {next_pc[15:cmsd_pkg::PAGE_BITS],
                            jump_operand[cmsd_pkg::PAGE_BITS-1:0]};
      cmsd_pkg::CMSD_JMP_LONG:
        jump_target_next = jump_operand;
      default:
        jump_target_next = next_pc;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      jump_target_reg       <= 16'h0000;
      jump_target_valid_reg <= 1'b0;
    end else begin
      jump_target_reg       <= jump_target_next;
      jump_target_valid_reg <= jump_valid;
    end
  end

  // Unused opcode folds onto no-operation
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opcode_is_nop_reg <= 1'b0;
    end else begin
      opcode_is_nop_reg <= (opcode == cmsd_pkg::OPC_NOP) || (opcode == cmsd_pkg::OPC_UNUSED);
    end
  end

  // Branch cycle counts; taken adds one except for the none and no-op kinds
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      branch_cycles_reg <= 3'h0;
    end else begin
      case (branch_kind)
        cmsd_pkg::CMSD_BR_CMP_IND: branch_cycles_reg <= cmsd_pkg::CYC_BR_IND + {2'b00, branch_taken};
        cmsd_pkg::CMSD_BR_CMP:     branch_cycles_reg <= cmsd_pkg::CYC_BR_MID + {2'b00, branch_taken};
        cmsd_pkg::CMSD_BR_DEC_REG,
        cmsd_pkg::CMSD_BR_ACC_NZ:  branch_cycles_reg <= cmsd_pkg::CYC_BR_SHORT + {2'b00, branch_taken};
        cmsd_pkg::CMSD_BR_DEC_DIR: branch_cycles_reg <= cmsd_pkg::CYC_BR_MID + {2'b00, branch_taken};
        cmsd_pkg::CMSD_BR_NOP:     branch_cycles_reg <= cmsd_pkg::CYC_NOP;
        default:                   branch_cycles_reg <= 3'h0;
      endcase
    end
  end

  // Code store gate: enable bit and factory area both checked
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      code_write_reg         <= 1'b0;
      code_write_refused_reg <= 1'b0;
    end else begin
      code_write_reg <= code_write_req
                        & program_store_control[cmsd_pkg::STORE_WREN_BIT]
                        & (code_write_addr < cmsd_pkg::FACTORY_BASE);
      code_write_refused_reg <= code_write_req
                        & (~program_store_control[cmsd_pkg::STORE_WREN_BIT]
                           | (code_write_addr >= cmsd_pkg::FACTORY_BASE));
    end
  end

  // Stack pointer next value; 8-bit arithmetic wraps naturally
  always_comb begin
    stack_top_pointer_next = stack_top_pointer_reg;
    if (sp_write) begin
      stack_top_pointer_next = sp_wdata;
    end else if (stack_ev.call) begin
      stack_top_pointer_next = stack_top_pointer_reg + 8'h02;
    end else if (stack_ev.push | stack_ev.inc) begin
      stack_top_pointer_next = stack_top_pointer_reg + 8'h01;
    end else if (stack_ev.ret) begin
      stack_top_pointer_next = stack_top_pointer_reg - 8'h02;
    end else if (stack_ev.pop | stack_ev.dec) begin
      stack_top_pointer_next = stack_top_pointer_reg - 8'h01;
    end
  end

  // Pointer always names the last used slot
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stack_top_pointer_reg <= cmsd_pkg::STACK_PTR_RESET;
      stack_write_addr_reg  <= 8'h00;
      stack_write_reg       <= 1'b0;
    end else begin
      stack_top_pointer_reg <= stack_top_pointer_next;
      stack_write_reg       <= ~sp_write & (stack_ev.push | stack_ev.call);
      stack_write_addr_reg  <= stack_top_pointer_reg + 8'h01;
    end
  end

  // Debug stack record
  cmsd_stack_record #(
    .WIDTH (REC_WIDTH)
  ) u_rec (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .ev            (stack_ev),
    .bit_in        (rec_bit_in),
    .flag_clear    (rec_flag_clear),
    .record_reg    (stack_record_reg),
    .overflow_reg  (stack_overflow_reg),
    .underflow_reg (stack_underflow_reg)
  );
endmodule : cmsd_top

/* File: cmsd_checker.sv */
// Purpose: Port assertions for the memory space decoder
// Assumes: Requests start on the fourth edge after reset release
// Notes:   Blind for three edges while the internal reset clears
`timescale 1ns/100ps
module cmsd_checker (
  input logic                     clk_sys,
  input logic                     reset_n,
  input cmsd_pkg::cmsd_data_req_t data_req,
  input logic [7:0]               bank_r0,
  input logic [7:0]               bank_r1,
  input logic [7:0]               program_status_word,
  input logic [7:0]               program_store_control,
  input logic                     code_write_req,
  input logic [15:0]              code_write_addr,
  input logic [15:0]              next_pc,
  input cmsd_pkg::cmsd_jump_t     jump_kind,
  input logic                     jump_valid,
  input logic [15:0]              jump_operand,
  input logic [7:0]               opcode,
  input cmsd_pkg::cmsd_stack_ev_t stack_ev,
  input logic                     sp_write,
  input logic                     rec_flag_clear,
  input cmsd_pkg::cmsd_data_dec_t data_dec_reg,
  input logic [4:0]               bank_reg_base_reg,
  input logic [15:0]              jump_target_reg,
  input logic                     opcode_is_nop_reg,
  input logic                     code_write_reg,
  input logic                     code_write_refused_reg,
  input logic [7:0]               stack_top_pointer_reg,
  input logic [7:0]               stack_write_addr_reg,
  input logic                     stack_write_reg,
  input logic                     stack_overflow_reg
);
  logic [1:0] live_cnt_reg;
  logic       live;
  // Count edges after release; the two-flop sync hides early answers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      live_cnt_reg <= 2'h0;
    end else if (live_cnt_reg != 2'h3) begin
      live_cnt_reg <= live_cnt_reg + 2'h1;
    end
  end
  assign live = (live_cnt_reg == 2'h3);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  AST_SP_RESET: assert property ($rose(reset_n) |-> (stack_top_pointer_reg == 8'h07)[*3])
    else $error("pointer not 0x07 after reset");
  AST_PUSH: assert property (live && stack_ev.push && !sp_write |=> stack_write_reg &&
    stack_write_addr_reg == 8'($past(stack_top_pointer_reg) + 8'h01) && stack_top_pointer_reg == stack_write_addr_reg)
    else $error("push address or pointer wrong");
  AST_DIRECT: assert property (live && data_req.valid && !data_req.indirect && !data_req.bit_op |=>
    data_dec_reg.sfr_sel == $past(data_req.addr[7]) && data_dec_reg.ram_sel != $past(data_req.addr[7]))
    else $error("direct access in wrong space");
  AST_INDIRECT: assert property (live && data_req.valid && data_req.indirect |=> data_dec_reg.ram_sel &&
    data_dec_reg.addr == ($past(data_req.use_r1) ? $past(bank_r1) : $past(bank_r0)))
    else $error("indirect access not via pointer");
  AST_BIT: assert property (live && data_req.valid && data_req.bit_op && !data_req.indirect && !data_req.addr[7] |=>
    data_dec_reg.bit_op && {data_dec_reg.addr, data_dec_reg.bit_pos} == {4'h2, $past(data_req.addr[6:0])})
    else $error("bit address mapped wrongly");
  AST_REL: assert property (live && jump_valid && jump_kind == cmsd_pkg::CMSD_JMP_REL |=>
    jump_target_reg == 16'($past(next_pc) + {{8{$past(jump_operand[7])}}, $past(jump_operand[7:0])}))
    else $error("relative target wrong");
  AST_CODE_WR: assert property (live && code_write_req |=> code_write_reg != code_write_refused_reg &&
    code_write_reg == ($past(program_store_control[0]) && $past(code_write_addr) < 16'hFE00))
    else $error("code write gate wrong");
  AST_NOP: assert property (live && opcode == 8'hA5 |=> opcode_is_nop_reg)
    else $error("unused opcode not a no-op");
  AST_BANK: assert property (live |=> bank_reg_base_reg == {$past(program_status_word[4:3]), 3'h0})
    else $error("bank base wrong");
  AST_OVF_HOLD: assert property (stack_overflow_reg && !rec_flag_clear |=> stack_overflow_reg)
    else $error("overflow flag dropped");
endmodule : cmsd_checker
bind cmsd_top cmsd_checker u_chk (.*);

/* File: cmsd_exec_model.sv */
// Purpose: Execution unit stand-in giving R0 and R1 of the active bank
// Assumes: Bank registers preloaded as pointers
// Notes:   Pointers aim at upper data RAM, never an SPECIAL_FUNCTION_REGISTER hole
`timescale 1ns/100ps
module cmsd_exec_model (
  input  logic [7:0] program_status_word,
  output logic [7:0] bank_r0,
  output logic [7:0] bank_r1
);
  // Pointer 0x80 + bank*8, so each bank and register is told apart
  assign bank_r0 = {3'h4, program_status_word[4:3], 3'h0};
  assign bank_r1 = {3'h4, program_status_word[4:3], 3'h1};
endmodule : cmsd_exec_model

/* File: tb_cpu_memory_space_decode.sv */
// Purpose: Self-checking bench for the memory space decoder
// Assumes: Answers appear one clock after a request is taken
// Notes:   Drive by NBA on the rising edge, read on the falling edge
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb_cpu_memory_space_decode;
  logic                     clk_sys = 1'b0;
  logic                     reset_n = 1'b0;
  cmsd_pkg::cmsd_data_req_t data_req = '0;
  cmsd_pkg::cmsd_jump_t     jump_kind = cmsd_pkg::CMSD_JMP_REL;
  cmsd_pkg::cmsd_branch_t   branch_kind = cmsd_pkg::CMSD_BR_NONE;
  cmsd_pkg::cmsd_stack_ev_t stack_ev = '0;
  cmsd_pkg::cmsd_data_dec_t data_dec_reg;
  logic [7:0]               program_status_word = '0, program_store_control = '0, opcode = '0, sp_wdata = '0;
  logic [7:0]               bank_r0, bank_r1, stack_top_pointer_reg, stack_write_addr_reg;
  logic [15:0]              code_write_addr = '0, next_pc = '0, jump_operand = '0, jump_target_reg;
  logic                     code_write_req = 1'b0, jump_valid = 1'b0, branch_taken = 1'b0;
  logic                     sp_write = 1'b0, rec_bit_in = 1'b0, rec_flag_clear = 1'b0;
  logic [4:0]               bank_reg_base_reg;
  logic [2:0]               branch_cycles_reg;
  logic [31:0]              stack_record_reg;
  logic                     jump_target_valid_reg, opcode_is_nop_reg, code_write_reg, code_write_refused_reg;
  logic                     stack_write_reg, stack_overflow_reg, stack_underflow_reg;
  int                       bad_count = 0;
  int                       checks = 0;
  logic [2:0]               base_cyc [1:6] = '{3'h4, 3'h3, 3'h2, 3'h2, 3'h3, 3'h1};

  always #20 clk_sys = ~clk_sys;
  cmsd_top #(.REC_WIDTH(32)) u_dut (.*);
  cmsd_exec_model u_exec (.*);

  // One-shot requests drop on the edge that takes them
  task automatic go;
    @(posedge clk_sys);
    stack_ev       <= '0;
    sp_write       <= 1'b0;
    code_write_req <= 1'b0;
    jump_valid     <= 1'b0;
    rec_flag_clear <= 1'b0;
    @(negedge clk_sys);
  endtask : go
  // Requests wait out the two-flop release
  task automatic rst;
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : rst
  task automatic ev(input logic [5:0] e, input logic b);
    @(posedge clk_sys);
    stack_ev   <= e;
    rec_bit_in <= b;
    go;
  endtask : ev
  task automatic dq(input logic [11:0] rq, input logic [14:0] ex);
    @(posedge clk_sys);
    data_req <= rq;
    go;
    `CHK("decode", ex, data_dec_reg)
  endtask : dq
  task automatic jp(input logic [1:0] k, input logic [15:0] pc, input logic [15:0] op, input logic [15:0] ex);
    @(posedge clk_sys);
    jump_kind    <= cmsd_pkg::cmsd_jump_t'(k);
    next_pc      <= pc;
    jump_operand <= op;
    jump_valid   <= 1'b1;
    go;
    `CHK("target", {1'b1, ex}, {jump_target_valid_reg, jump_target_reg})
  endtask : jp
  task automatic cw(input logic [7:0] ctl, input logic [15:0] a, input logic ok);
    @(posedge clk_sys);
    program_store_control <= ctl;
    code_write_addr       <= a;
    code_write_req        <= 1'b1;
    go;
    `CHK("code write", {ok, !ok}, {code_write_reg, code_write_refused_reg})
  endtask : cw
  task automatic results;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  initial begin
    rst;
    `CHK("sp", 8'h07, stack_top_pointer_reg)
    ev(6'h20, 1'b1);
    `CHK("push", {1'b1, 16'h0808}, {stack_write_reg, stack_write_addr_reg, stack_top_pointer_reg})
    ev(6'h08, 1'b1);
    `CHK("call", {8'h0A, 32'h7}, {stack_top_pointer_reg, stack_record_reg})
    ev(6'h04, 1'b0);
    `CHK("ret", {8'h08, 32'h1}, {stack_top_pointer_reg, stack_record_reg})
    ev(6'h01, 1'b0);
    `CHK("dec", {8'h07, 32'h0}, {stack_top_pointer_reg, stack_record_reg})
    ev(6'h02, 1'b1);
    `CHK("inc", {8'h08, 32'h1}, {stack_top_pointer_reg, stack_record_reg})
    ev(6'h10, 1'b0);
    `CHK("pop", {8'h07, 32'h0}, {stack_top_pointer_reg, stack_record_reg})
    @(posedge clk_sys);
    sp_write <= 1'b1;
    sp_wdata <= 8'hFF;
    go;
    ev(6'h20, 1'b0);
    `CHK("wrap", 16'h0000, {stack_write_addr_reg, stack_top_pointer_reg})
    // Every bank, pointer taken from R0 of that bank
    for (int b = 0; b < 4; b++) begin
      @(posedge clk_sys);
      program_status_word <= 8'(b << 3);
      data_req            <= {4'b1100, 8'h00};
      go;
      `CHK("bank", 8'(b * 8), 8'(bank_reg_base_reg))
      `CHK("pointer", 8'(8'h80 + b * 8), data_dec_reg.addr)
    end
    dq({4'b1101, 8'h00}, {4'b1000, 8'h99, 3'h0});
    dq({4'b1000, 8'h7F}, {4'b1000, 8'h7F, 3'h0});
    dq({4'b1000, 8'h80}, {4'b0100, 8'h80, 3'h0});
    dq({4'b1010, 8'h13}, {4'b1010, 8'h22, 3'h3});
    dq({4'b1000, 8'h13}, {4'b1000, 8'h13, 3'h0});
    dq({4'b1010, 8'h7F}, {4'b1010, 8'h2F, 3'h7});
    dq({4'b1010, 8'h8B}, {4'b0110, 8'h88, 3'h3});
    jp(2'h0, 16'h1000, 16'h00FE, 16'h0FFE);
    jp(2'h0, 16'h10F0, 16'h007F, 16'h116F);
    jp(2'h1, 16'hF802, 16'h0001, 16'hF801);
    jp(2'h2, 16'h0003, 16'hFFFF, 16'hFFFF);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      opcode <= (i == 0) ? 8'hA5 : (i == 1) ? 8'h00 : 8'hA4;
      go;
      `CHK("nop", i != 2, opcode_is_nop_reg)
    end
    for (int k = 1; k <= 6; k++) begin
      for (int t = 0; t < 2; t++) begin
        @(posedge clk_sys);
        branch_kind  <= cmsd_pkg::cmsd_branch_t'(k);
        branch_taken <= t[0];
        go;
        `CHK("cycles", 3'(base_cyc[k] + ((t == 1 && k != 6) ? 1 : 0)), branch_cycles_reg)
      end
    end
    cw(8'h00, 16'h1234, 1'b0);
    cw(8'h01, 16'h1234, 1'b1);
    cw(8'h02, 16'h0100, 1'b0);
    cw(8'h01, 16'hFDFF, 1'b1);
    cw(8'h01, 16'hFE00, 1'b0);
    rst;
    repeat (32) ev(6'h20, 1'b1);
    `CHK("full", {1'b0, 32'hFFFF_FFFF}, {stack_overflow_reg, stack_record_reg})
    ev(6'h20, 1'b1);
    `CHK("overflow", 1'b1, stack_overflow_reg)
    @(posedge clk_sys);
    rec_flag_clear <= 1'b1;
    go;
    `CHK("cleared", 1'b0, stack_overflow_reg)
    rst;
    ev(6'h10, 1'b0);
    `CHK("underflow", 1'b1, stack_underflow_reg)
    results;
  end
  // Whole run needs some 200 cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    results;
  end
endmodule : tb_cpu_memory_space_decode
